/* File: vis_map.svh */
// Constants for the vectored interrupt source block
`ifndef VIS_MAP_SVH
`define VIS_MAP_SVH

// ----------------------------------------
// Vector table
// ----------------------------------------
`define VIS_RESET_VEC 16'h0000
`define VIS_VEC_BASE 16'h0002
`define VIS_VEC_STEP 16'h0002
`define VIS_NUM_SRC 12

// ----------------------------------------
// Source index, lowest wins
// ----------------------------------------
`define VIS_SRC_BUSRST 0
`define VIS_SRC_T128 1
`define VIS_SRC_T1024 2
`define VIS_SRC_EP 3
`define VIS_SRC_HUB 8
`define VIS_SRC_DAC 9
`define VIS_SRC_GPIO 10
`define VIS_SRC_I2C 11

// ----------------------------------------
// Global enable bit positions
// ----------------------------------------
`define VIS_GIE_BUSRST 0
`define VIS_GIE_T128 1
`define VIS_GIE_T1024 2
`define VIS_GIE_HUB 3
`define VIS_GIE_GPIO 5
`define VIS_GIE_I2C 6

// ----------------------------------------
// Registers cleared on bus reset, one clear line each
// ----------------------------------------
`define VIS_CLR_ADDR_A 8'h10
`define VIS_CLR_ADDR_B 8'h40
`define VIS_CLR_CONN 8'h48
`define VIS_CLR_SPEED 8'h4a
`define VIS_CLR_SUSP 8'h4d
`define VIS_CLR_RESUME 8'h4e
`define VIS_CLR_DATA 8'h50
`define VIS_CLR_FORCE 8'h51
`define VIS_CLR_ALL 8'hff
`define VIS_PSC_BUSRST_BIT 5

// ----------------------------------------
// Timing
// ----------------------------------------
`define VIS_CLK_NS 25
`define VIS_SE0_MIN_NS 12000
`define VIS_SE0_MAX_NS 16000
`define VIS_SE0_CYC ((`VIS_SE0_MIN_NS + `VIS_CLK_NS - 1) / `VIS_CLK_NS)
`define VIS_CALL_CYC 10
`define VIS_JMP_CYC 5

`endif

/* File: vis_pkg.sv */
// Types for the vectored interrupt source block
package vis_pkg;
  typedef logic [15:0] vis_addr_t;
  typedef logic [11:0] vis_src_t;
  typedef enum logic [1:0] {VIS_BOOT, VIS_IDLE, VIS_CALL} vis_svc_t;
endpackage

/* File: vis_se0_det.sv */
// Upstream single-ended zero detector for bus reset
`timescale 1ns/10ps
`include "vis_map.svh"
module vis_se0_det #(
  parameter int SE0_CYC = `VIS_SE0_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Upstream lines
  input wire logic dp_in,
  input wire logic dm_in,
  // Events
  output logic det_out,
  output logic end_out
);
  logic [1:0] dp_sync_q, dm_sync_q;
  logic [15:0] cnt_q, cnt_d;
  logic seen_q, seen_d;
  logic det_q, det_d, end_q, end_d;
  logic se0;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dp_sync_q <= 2'h0;
      dm_sync_q <= 2'h0;
    end
    else
    begin
      dp_sync_q <= {dp_sync_q[0], dp_in};
      dm_sync_q <= {dm_sync_q[0], dm_in};
    end
  end

  assign se0 = !dp_sync_q[1] && !dm_sync_q[1];

  // ----------------------------------------
  // Persistence timer
  // ----------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    seen_d = seen_q;
    det_d = 1'b0;
    end_d = 1'b0;
    if (se0)
    begin
      if (cnt_q == 16'(SE0_CYC - 1))
      begin
        det_d = !seen_q;
        seen_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 16'h1;
    end
    else
    begin
      cnt_d = 16'h0;
      seen_d = 1'b0;
      end_d = seen_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q <= 16'h0;
      seen_q <= 1'b0;
      det_q <= 1'b0;
      end_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      det_q <= det_d;
      end_q <= end_d;
    end
  end

  assign det_out = det_q;
  assign end_out = end_q;

  end_after_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) end_out |-> $past(seen_q))
    else $error("bus reset end without detect");
endmodule

/* File: vis_core.sv */
// Vectored interrupt controller with its source conditioning
`timescale 1ns/10ps
`include "vis_map.svh"
module vis_core #(
  parameter int GPIO_W = 11,
  parameter int SE0_CYC = `VIS_SE0_CYC,
  parameter int CALL_CYC = `VIS_CALL_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Enables
  input wire logic [7:0] glb_ie_in,
  input wire logic [4:0] ep_ie_in,
  input wire logic dac_ie_in,
  // Processor core
  input wire logic cpu_boundary_in,
  input wire logic cpu_ei_in,
  input wire logic cpu_di_in,
  output logic gie_out,
  output logic push_out,
  output logic call_busy_out,
  output logic pc_load_out,
  output vis_pkg::vis_addr_t pc_addr_out,
  output vis_pkg::vis_src_t pending_out,
  // Upstream port and bus reset
  input wire logic usb_dp_in,
  input wire logic usb_dm_in,
  input wire logic startup_active_in,
  input wire logic bus_rst_clr_in,
  output logic bus_rst_flag_out,
  output logic [7:0] reg_clr_out,
  output logic startup_abort_out,
  // Timer, endpoint, hub and converter events
  input wire logic tmr_128_in,
  input wire logic tmr_1024_in,
  input wire logic [4:0] ep_host_ack_in,
  input wire logic [4:0] ep_dev_ack_in,
  input wire logic [3:0] hub_conn_chg_in,
  input wire logic [3:0] hub_forced_in,
  input wire logic [3:0] hub_babble_in,
  input wire logic [3:0] hub_resume_in,
  input wire logic [3:0] hub_port_en_in,
  input wire logic dac_evt_in,
  // GPIO
  input wire logic [GPIO_W-1:0] gpio_pin_in,
  input wire logic [GPIO_W-1:0] gpio_pie_in,
  input wire logic [GPIO_W-1:0] gpio_rise_in,
  // I2C engine and control write
  input wire logic i2c_rx_byte_in,
  input wire logic i2c_after_start_in,
  input wire logic i2c_tx_byte_in,
  input wire logic i2c_tx_acked_in,
  input wire logic i2c_stop_in,
  input wire logic i2c_arb_lost_in,
  input wire logic i2c_ack_bit_in,
  input wire logic i2c_ctl_wr_in,
  input wire logic i2c_wr_busy_in,
  input wire logic i2c_wr_msel_in,
  input wire logic i2c_wr_flag_clr_in,
  output logic i2c_busy_out,
  output logic master_select_bit_out,
  output logic arbitration_lost_flag_out,
  output logic i2c_first_byte_out,
  output logic i2c_stop_flag_out,
  output logic i2c_master_ack_out,
  output logic i2c_stop_req_out
);
  import vis_pkg::*;

  localparam int NS = `VIS_NUM_SRC;

  logic se0_det, se0_end;
  logic tmr_128_q, tmr_1024_q;
  logic [GPIO_W-1:0] g_s1_q, g_s2_q, g_act_prev_q, g_act;
  logic g_lock_q, g_lock_d;
  logic [3:0] g_idx_q, g_idx_d;
  logic gpio_evt;
  logic i2c_evt;
  logic brst_q, brst_d;
  logic [7:0] clr_q, clr_d;
  logic abort_q, abort_d;
  logic busy_q, busy_d, msel_q, msel_d, arb_q, arb_d;
  logic first_q, first_d, stopf_q, stopf_d, ackm_q, ackm_d;
  logic await_q, await_d, rxnak_q, rxnak_d, stopreq_q, stopreq_d;
  vis_src_t evt, en, req, pend_q, pend_d, grant;
  vis_svc_t st_q, st_d;
  vis_addr_t pc_q, pc_d;
  logic [3:0] cnt_q, cnt_d;
  logic gie_q, gie_d, push_q, push_d, load_q, load_d;
  logic svc_go;

  // ----------------------------------------
  // Bus reset detection
  // ----------------------------------------
  vis_se0_det #(.SE0_CYC(SE0_CYC)) u_se0 (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .dp_in(usb_dp_in),
    .dm_in(usb_dm_in),
    .det_out(se0_det),
    .end_out(se0_end)
  );

  always_comb
  begin
    brst_d = se0_det || (brst_q && !bus_rst_clr_in);
    clr_d = se0_det ? `VIS_CLR_ALL : 8'h0;
    abort_d = se0_det && startup_active_in;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      brst_q <= 1'b0;
      clr_q <= 8'h0;
      abort_q <= 1'b0;
    end
    else
    begin
      brst_q <= brst_d;
      clr_q <= clr_d;
      abort_q <= abort_d;
    end
  end

  // ----------------------------------------
  // GPIO conditioning
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      g_s1_q <= '0;
      g_s2_q <= '0;
      // Starts active so a falling-active pin gives no false edge
      g_act_prev_q <= '1;
      tmr_128_q <= 1'b0;
      tmr_1024_q <= 1'b0;
    end
    else
    begin
      g_s1_q <= gpio_pin_in;
      g_s2_q <= g_s1_q;
      g_act_prev_q <= g_act;
      tmr_128_q <= tmr_128_in;
      tmr_1024_q <= tmr_1024_in;
    end
  end

  // Active level per pin from its port polarity
  assign g_act = ~(g_s2_q ^ gpio_rise_in);

  always_comb
  begin
    g_lock_d = g_lock_q;
    g_idx_d = g_idx_q;
    gpio_evt = 1'b0;
    if (g_lock_q && (!g_act[g_idx_q] || !gpio_pie_in[g_idx_q]))
      g_lock_d = 1'b0;
    if (!g_lock_q)
    begin
      for (int i = GPIO_W - 1; i >= 0; i--)
      begin
        if (gpio_pie_in[i] && g_act[i] && !g_act_prev_q[i])
        begin
          gpio_evt = 1'b1;
          g_lock_d = 1'b1;
          g_idx_d = 4'(i);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      g_lock_q <= 1'b0;
      g_idx_q <= 4'h0;
    end
    else
    begin
      g_lock_q <= g_lock_d;
      g_idx_q <= g_idx_d;
    end
  end

  // ----------------------------------------
  // I2C conditions
  // ----------------------------------------
  always_comb
  begin
    busy_d = busy_q;
    msel_d = msel_q;
    stopreq_d = 1'b0;
    first_d = first_q;
    ackm_d = ackm_q;
    rxnak_d = rxnak_q;
    await_d = await_q;
    i2c_evt = 1'b0;
    arb_d = arb_q && !(i2c_ctl_wr_in && i2c_wr_flag_clr_in);
    stopf_d = stopf_q && !(i2c_ctl_wr_in && i2c_wr_flag_clr_in);
    if (i2c_rx_byte_in || i2c_tx_byte_in)
      busy_d = 1'b0;
    if (i2c_rx_byte_in)
    begin
      i2c_evt = 1'b1;
      first_d = i2c_after_start_in;
      rxnak_d = !i2c_ack_bit_in;
    end
    if (i2c_tx_byte_in)
    begin
      i2c_evt = 1'b1;
      ackm_d = i2c_tx_acked_in;
    end
    if (i2c_ctl_wr_in)
    begin
      busy_d = i2c_wr_busy_in || busy_d;
      msel_d = i2c_wr_msel_in;
      stopreq_d = msel_q && !i2c_wr_msel_in;
    end
    if (i2c_arb_lost_in)
    begin
      msel_d = 1'b0;
      arb_d = 1'b1;
      await_d = 1'b1;
    end
    if (i2c_stop_in)
    begin
      if (await_q)
      begin
        i2c_evt = 1'b1;
        await_d = 1'b0;
      end
      else if (!rxnak_q)
      begin
        i2c_evt = 1'b1;
        stopf_d = 1'b1;
      end
      rxnak_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_q <= 1'b0;
      msel_q <= 1'b0;
      arb_q <= 1'b0;
      first_q <= 1'b0;
      stopf_q <= 1'b0;
      ackm_q <= 1'b0;
      await_q <= 1'b0;
      rxnak_q <= 1'b0;
      stopreq_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      msel_q <= msel_d;
      arb_q <= arb_d;
      first_q <= first_d;
      stopf_q <= stopf_d;
      ackm_q <= ackm_d;
      await_q <= await_d;
      rxnak_q <= rxnak_d;
      stopreq_q <= stopreq_d;
    end
  end

  // ----------------------------------------
  // Pending, enable and priority
  // ----------------------------------------
  always_comb
  begin
    evt = '0;
    evt[`VIS_SRC_BUSRST] = se0_end;
    evt[`VIS_SRC_T128] = tmr_128_in && !tmr_128_q;
    evt[`VIS_SRC_T1024] = tmr_1024_in && !tmr_1024_q;
    evt[`VIS_SRC_EP +: 5] = ep_host_ack_in | ep_dev_ack_in;
    // Hub change, gated babble and resume
    evt[`VIS_SRC_HUB] = |((hub_conn_chg_in & ~hub_forced_in) | ((hub_babble_in | hub_resume_in) & hub_port_en_in));
    evt[`VIS_SRC_DAC] = dac_evt_in;
    evt[`VIS_SRC_GPIO] = gpio_evt;
    evt[`VIS_SRC_I2C] = i2c_evt;
    en = '0;
    en[`VIS_SRC_BUSRST] = glb_ie_in[`VIS_GIE_BUSRST];
    en[`VIS_SRC_T128] = glb_ie_in[`VIS_GIE_T128];
    en[`VIS_SRC_T1024] = glb_ie_in[`VIS_GIE_T1024];
    en[`VIS_SRC_EP +: 5] = ep_ie_in;
    en[`VIS_SRC_HUB] = glb_ie_in[`VIS_GIE_HUB];
    en[`VIS_SRC_DAC] = dac_ie_in;
    en[`VIS_SRC_GPIO] = glb_ie_in[`VIS_GIE_GPIO];
    en[`VIS_SRC_I2C] = glb_ie_in[`VIS_GIE_I2C];
    req = pend_q & en;
    grant = req & (~req + 12'h1);
  end

  assign svc_go = (st_q == VIS_IDLE) && cpu_boundary_in && gie_q && (|req);

  // ----------------------------------------
  // Service sequencer
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    pc_d = pc_q;
    cnt_d = cnt_q;
    push_d = 1'b0;
    load_d = 1'b0;
    gie_d = gie_q;
    if (cpu_ei_in)
      gie_d = 1'b1;
    if (cpu_di_in)
      gie_d = 1'b0;
    // Latch until serviced, new event wins
    pend_d = (pend_q & ~(svc_go ? grant : 12'h0)) | evt;
    case (st_q)
      VIS_BOOT:
      begin
        pc_d = `VIS_RESET_VEC;
        load_d = 1'b1;
        st_d = VIS_IDLE;
      end
      VIS_IDLE:
      begin
        if (svc_go)
        begin
          gie_d = 1'b0;
          push_d = 1'b1;
          pc_d = `VIS_VEC_BASE;
          for (int i = 0; i < NS; i++)
          begin
            if (grant[i])
              pc_d = 16'(`VIS_VEC_BASE + i * `VIS_VEC_STEP);
          end
          cnt_d = 4'(CALL_CYC - 1);
          st_d = VIS_CALL;
        end
      end
      VIS_CALL:
      begin
        if (cnt_q == 4'h0)
        begin
          load_d = 1'b1;
          st_d = VIS_IDLE;
        end
        else
          cnt_d = cnt_q - 4'h1;
      end
      default:
        st_d = VIS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= VIS_BOOT;
      pc_q <= 16'h0;
      cnt_q <= 4'h0;
      gie_q <= 1'b0;
      push_q <= 1'b0;
      load_q <= 1'b0;
      pend_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      pc_q <= pc_d;
      cnt_q <= cnt_d;
      gie_q <= gie_d;
      push_q <= push_d;
      load_q <= load_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign gie_out = gie_q;
  assign push_out = push_q;
  assign call_busy_out = (st_q == VIS_CALL);
  assign pc_load_out = load_q;
  assign pc_addr_out = pc_q;
  assign pending_out = pend_q;
  assign bus_rst_flag_out = brst_q;
  assign reg_clr_out = clr_q;
  assign startup_abort_out = abort_q;
  assign i2c_busy_out = busy_q;
  assign master_select_bit_out = msel_q;
  assign arbitration_lost_flag_out = arb_q;
  assign i2c_first_byte_out = first_q;
  assign i2c_stop_flag_out = stopf_q;
  assign i2c_master_ack_out = ackm_q;
  assign i2c_stop_req_out = stopreq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  prio_top_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    svc_go && req[0] |=> pc_addr_out == 16'h0002) else $error("bus reset not preferred");
  gpio_slot_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    svc_go && grant[10] |=> pc_addr_out == 16'h0016) else $error("gpio vector wrong");
  boot_fetch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_q == VIS_BOOT |=> pc_load_out && pc_addr_out == 16'h0000) else $error("reset fetch wrong");
  call_len_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    svc_go |-> ##11 pc_load_out) else $error("call length wrong");
  svc_gie_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    svc_go && !cpu_ei_in |=> !gie_out && push_out) else $error("service did not disable");
  rst_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    se0_det |=> reg_clr_out == 8'hff && bus_rst_flag_out) else $error("bus reset clear missing");
  arb_lost_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    i2c_arb_lost_in |=> !master_select_bit_out && arbitration_lost_flag_out) else $error("arb loss wrong");
  busy_clr_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    i2c_rx_byte_in && !i2c_ctl_wr_in |=> !i2c_busy_out) else $error("busy not cleared");
  gpio_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    g_lock_q && g_act[g_idx_q] && gpio_pie_in[g_idx_q] |-> !gpio_evt) else $error("gpio lock missing");
endmodule

/* File: vis_cpu_model.sv */
// Processor core stand-in: instruction boundaries and ISR enable
`timescale 1ns/10ps
module vis_cpu_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Firmware behaviour
  input wire logic slow_in,
  input wire logic auto_ei_in,
  input wire logic ei_req_in,
  // Controller side
  input wire logic pc_load_in,
  output logic boundary_out,
  output logic ei_out
);
  logic [1:0] phase_q;
  logic [2:0] isr_q;
  logic isr_ei_q;
  // Combinational request path avoids a race with the bench
  assign ei_out = ei_req_in || isr_ei_q;
  // ----------------------------------------
  // Instruction stream
  // ----------------------------------------
  always @(negedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q <= 2'h0;
      isr_q <= 3'h0;
      isr_ei_q <= 1'b0;
      boundary_out <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      boundary_out <= !slow_in || (phase_q == 2'h3);
      if (pc_load_in)
        isr_q <= 3'h4;
      else if (isr_q != 3'h0)
        isr_q <= isr_q - 3'h1;
      isr_ei_q <= auto_ei_in && (isr_q == 3'h1);
    end
  end
endmodule

/* File: vectored_interrupt_sources_tb.sv */
// Self-checking bench for the vectored interrupt source block
`timescale 1ns/10ps
module vectored_interrupt_sources_tb;
  import vis_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, dp = 1'b1, dm = 1'b0, di = 1'b0, slow = 1'b0, auto_ei = 1'b1;
  logic ei_req = 1'b0, dac_ie = 1'b1, st_act = 1'b0, brst_clr = 1'b0, t128 = 1'b0, t1024 = 1'b0;
  logic dac_evt = 1'b0, rx = 1'b0, aft_st = 1'b0, tx = 1'b0, tx_ack = 1'b0, stp = 1'b0, arb = 1'b0;
  logic ack_bit = 1'b1, cwr = 1'b0, w_busy = 1'b0, w_msel = 1'b0, w_fclr = 1'b0;
  logic [7:0] gie_en = 8'h6f;
  logic [4:0] ep_ie = 5'h1f, ep_host = 5'h00, ep_dev = 5'h00;
  logic [3:0] hub_chg = 4'h0, hub_frc = 4'h0, hub_bab = 4'h0, hub_res = 4'h0, hub_en = 4'h0;
  logic [10:0] gp_pin = 11'h004, gp_pie = 11'h007, gp_rise = 11'h003;
  logic bnd, ei, gie_o, push, pcl, brf, sab, ibusy, msel, arbf, fb, sflag, mack, sreq, cbusy;
  logic [7:0] rclr;
  vis_addr_t pca;
  vis_src_t pend;
  int mismatches = 0, checked = 0, cycles = 0, i, n;

  vis_core #(.SE0_CYC(20)) dut (
    .sys_clk_in(sys_clk), .rst_in(rst), .glb_ie_in(gie_en), .ep_ie_in(ep_ie), .dac_ie_in(dac_ie),
    .cpu_boundary_in(bnd), .cpu_ei_in(ei), .cpu_di_in(di), .gie_out(gie_o), .push_out(push),
    .call_busy_out(cbusy), .pc_load_out(pcl), .pc_addr_out(pca), .pending_out(pend),
    .usb_dp_in(dp), .usb_dm_in(dm), .startup_active_in(st_act), .bus_rst_clr_in(brst_clr),
    .bus_rst_flag_out(brf), .reg_clr_out(rclr), .startup_abort_out(sab),
    .tmr_128_in(t128), .tmr_1024_in(t1024), .ep_host_ack_in(ep_host), .ep_dev_ack_in(ep_dev),
    .hub_conn_chg_in(hub_chg), .hub_forced_in(hub_frc), .hub_babble_in(hub_bab),
    .hub_resume_in(hub_res), .hub_port_en_in(hub_en), .dac_evt_in(dac_evt),
    .gpio_pin_in(gp_pin), .gpio_pie_in(gp_pie), .gpio_rise_in(gp_rise),
    .i2c_rx_byte_in(rx), .i2c_after_start_in(aft_st), .i2c_tx_byte_in(tx), .i2c_tx_acked_in(tx_ack),
    .i2c_stop_in(stp), .i2c_arb_lost_in(arb), .i2c_ack_bit_in(ack_bit), .i2c_ctl_wr_in(cwr),
    .i2c_wr_busy_in(w_busy), .i2c_wr_msel_in(w_msel), .i2c_wr_flag_clr_in(w_fclr),
    .i2c_busy_out(ibusy), .master_select_bit_out(msel), .arbitration_lost_flag_out(arbf),
    .i2c_first_byte_out(fb), .i2c_stop_flag_out(sflag), .i2c_master_ack_out(mack),
    .i2c_stop_req_out(sreq)
  );

  vis_cpu_model cpu (
    .sys_clk_in(sys_clk), .rst_in(rst), .slow_in(slow), .auto_ei_in(auto_ei), .ei_req_in(ei_req),
    .pc_load_in(pcl), .boundary_out(bnd), .ei_out(ei)
  );

  // ----------------------------------------
  // Clock and run limit
  // ----------------------------------------
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task en;
    ei_req = 1'b1;
    tick(1);
    ei_req = 1'b0;
  endtask

  // One-cycle event on source k
  task fire(input int k);
    case (k)
      1: t128 = 1'b1;
      2: t1024 = 1'b1;
      8: hub_chg = 4'h1;
      9: dac_evt = 1'b1;
      10: gp_pin[0] = 1'b1;
      11: rx = 1'b1;
      default: ep_host[k-3] = 1'b1;
    endcase
    tick(1);
    {t128, t1024, dac_evt, rx} = 4'h0;
    hub_chg = 4'h0;
    ep_host = 5'h00;
    gp_pin[0] = 1'b0;
    // Gap so a following event is not set in the same step
    tick(1);
  endtask

  // Wait for entry, then time the automatic call
  task svc(input logic [15:0] vec);
    n = 0;
    while (push !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    chk(pca, vec, "vector");
    chk(gie_o, 1'b0, "gie");
    chk(cbusy, 1'b1, "call busy");
    n = 0;
    while (pcl !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'h000a, "call");
    chk(cbusy, 1'b0, "call done");
  endtask

  // Single control write, no polling of busy first
  task wr(input logic b, input logic m, input logic f);
    {cwr, w_busy, w_msel, w_fclr} = {1'b1, b, m, f};
    tick(1);
    cwr = 1'b0;
  endtask

  task pls_stop;
    stp = 1'b1;
    tick(1);
    stp = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    tick(12);
    rst = 1'b0;
    tick(1);
    chk(pcl, 1'b1, "boot load");
    chk(pca, 16'h0000, "boot addr");
    en();
    for (i = 1; i < 12; i++)
    begin
      fire(i);
      svc(16'h0002 + 16'(2 * i));
    end
    tick(8);
    di = 1'b1;
    tick(1);
    di = 1'b0;
    ep_ie = 5'h00;
    fire(11);
    fire(9);
    fire(3);
    fire(1);
    tick(2);
    chk(pend, 12'ha0a, "latched");
    slow = 1'b1;
    en();
    svc(16'h0004);
    chk(pend, 12'ha08, "others kept");
    svc(16'h0014);
    svc(16'h0018);
    tick(12);
    chk(pend, 12'h008, "masked");
    ep_ie = 5'h1f;
    svc(16'h0008);
    slow = 1'b0;
    dp = 1'b0;
    tick(10);
    dp = 1'b1;
    tick(30);
    chk(brf, 1'b0, "short se0");
    st_act = 1'b1;
    dp = 1'b0;
    n = 0;
    while (rclr !== 8'hff && n < 60)
    begin
      tick(1);
      n++;
    end
    chk(16'(n >= 20), 16'h0001, "se0 time");
    chk(rclr, 8'hff, "clear");
    chk(sab, 1'b1, "abort");
    tick(1);
    chk(brf, 1'b1, "flag");
    chk(rclr, 8'h00, "clear once");
    tick(30);
    chk(pend[0], 1'b0, "early");
    dp = 1'b1;
    st_act = 1'b0;
    svc(16'h0002);
    brst_clr = 1'b1;
    tick(1);
    brst_clr = 1'b0;
    tick(1);
    chk(brf, 1'b0, "flag clr");
    ep_dev = 5'h10;
    tick(1);
    ep_dev = 5'h00;
    svc(16'h0010);
    auto_ei = 1'b0;
    hub_frc = 4'h2;
    hub_chg = 4'h2;
    hub_bab = 4'h4;
    tick(1);
    {hub_chg, hub_bab, hub_frc} = 12'h000;
    tick(2);
    chk(pend[8], 1'b0, "forced");
    hub_en = 4'h8;
    hub_res = 4'h8;
    tick(1);
    hub_res = 4'h0;
    tick(1);
    chk(pend[8], 1'b1, "resume");
    gp_pin[2] = 1'b0;
    tick(6);
    chk(pend[10], 1'b1, "falling");
    auto_ei = 1'b1;
    en();
    svc(16'h0012);
    svc(16'h0016);
    auto_ei = 1'b0;
    gp_pin[1] = 1'b1;
    tick(8);
    chk(pend[10], 1'b0, "held");
    gp_pin[2] = 1'b1;
    gp_pin[1] = 1'b0;
    tick(4);
    gp_pin[1] = 1'b1;
    tick(6);
    chk(pend[10], 1'b1, "released");
    gp_pin[1] = 1'b0;
    gie_en[2:1] = 2'h0;
    wr(1'b1, 1'b1, 1'b0);
    chk(msel, 1'b1, "master");
    arb = 1'b1;
    tick(1);
    arb = 1'b0;
    chk(msel, 1'b0, "arb msel");
    chk(arbf, 1'b1, "arb flag");
    chk(pend[11], 1'b0, "arb wait");
    pls_stop();
    chk(pend[11], 1'b1, "arb stop");
    wr(1'b1, 1'b0, 1'b1);
    chk(arbf, 1'b0, "flag clr");
    aft_st = 1'b1;
    rx = 1'b1;
    tick(1);
    {aft_st, rx} = 2'h0;
    chk(fb, 1'b1, "first");
    chk(ibusy, 1'b0, "busy");
    tx = 1'b1;
    tx_ack = 1'b1;
    tick(1);
    {tx, tx_ack} = 2'h0;
    chk(mack, 1'b1, "tx ack");
    pls_stop();
    chk(sflag, 1'b1, "stop");
    wr(1'b0, 1'b0, 1'b1);
    ack_bit = 1'b0;
    fire(11);
    pls_stop();
    chk(sflag, 1'b0, "nack stop");
    wr(1'b1, 1'b1, 1'b0);
    tick(1);
    wr(1'b0, 1'b0, 1'b0);
    n = 0;
    while (sreq !== 1'b1 && n < 4)
    begin
      tick(1);
      n++;
    end
    chk(16'(n < 4), 16'h0001, "stop req");
    tick(4);
    stop_test();
  end
endmodule
